// File: pkg/tgc_consts.svh
// What this block does
// - Count source is system clock over four when select is 0, external pin when 1.
// - Internal source advances count once per instruction cycle times prescale ratio.
// - Counter mode increments on external rising edges, synchronized or asynchronous.
// - Counter mode ignores rising edges until one falling edge has been seen.
// - Count clock is divided by 1, 2, 4 or 8 from a two-bit field.
// - Prescale counter is hidden from software and cleared on any count byte write.
// - Writing either count byte updates the running counter at once.
// - Oscillator enable bit turns the low-power oscillator on; it runs in sleep.
// - Oscillator option honoured only with internal oscillator or LP system clock.
// - With oscillator on, port A dir bits 5:4 read 1 and data bits read 0.
// - Sync bypass bit counts input unsynchronized; synchronizer idles in sleep.
// - Asynchronous counter keeps counting in sleep and overflow can wake the core.
// - Mode switches may lose one increment or add one spurious increment.
// - Count byte reads are valid while counting asynchronously.
// - Gate comes from gate pin or comparator 2 output per gate source bit.
// - Gate applies only while gate enable is set; otherwise counting is ungated.
// - Gate invert bit flips the selected gate for either source.
// - Count rolls from FFFF to 0000 and sets the overflow flag.
// - Interrupt needs timer, peripheral and global enables; flag stays until cleared.
// - Sleep counting only in asynchronous counter mode; wake needs on and enables.
// - Wake resumes next instruction; with global enable it vectors to 0004h.
`ifndef TGC_CONSTS_SVH
`define TGC_CONSTS_SVH
// Register byte offsets
`define TGC_OFS_CTRL 12'h000
`define TGC_OFS_CNT_LO 12'h004
`define TGC_OFS_CNT_HI 12'h008
`define TGC_OFS_CMP_CTRL 12'h00C
`define TGC_OFS_FLAG 12'h010
`define TGC_OFS_IRQ_EN 12'h014
`define TGC_OFS_IRQ_CTRL 12'h018
`define TGC_OFS_PORTA 12'h01C
// Control register fields
`define TGC_B_ON 0
`define TGC_B_CS 1
`define TGC_B_SYNC 2
`define TGC_B_OSCEN 3
`define TGC_B_PS_LO 4
`define TGC_B_GE 6
`define TGC_B_GINV 7
// Other fields
`define TGC_B_GSS 1
`define TGC_B_OVF 0
`define TGC_B_PERIPH_IRQ_ENABLE 6
`define TGC_B_GIE 7
// Reset values
`define TGC_RST_CTRL 8'h00
`define TGC_RST_CMP 8'h02
`define TGC_ISR_VECTOR 16'h0004
`define TGC_CNT_MAX 16'hFFFF
// Instruction cycle is four system clocks
`define TGC_CLKS_PER_CYCLE 4
`endif

// File: pkg/tgc_pkg.sv
package tgc_pkg;
  // What steers the count event
  typedef enum logic [1:0] {
    TGC_SRC_INTERNAL = 2'b00,
    TGC_SRC_EXT_SYNC = 2'b01,
    TGC_SRC_EXT_ASYNC = 2'b10
  } tgc_src_t;
  typedef logic [15:0] tgc_count_t;
endpackage

// File: src/tgc_timer.sv
`timescale 1ns/100ps
`default_nettype none
`include "tgc_consts.svh"
module tgc_timer
  import tgc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Count and gate inputs
  input wire logic ext_count_input_i,
  input wire logic lp_osc_clk_i,
  input wire logic gate_pin_i,
  input wire logic comparator2_output_i,
  // System state
  input wire logic sleep_i,
  input wire logic osc_option_ok_i,
  input wire logic [5:0] porta_dir_i,
  input wire logic [5:0] porta_data_i,
  // Status outputs
  output logic lp_osc_run_o,
  output logic irq_o,
  output logic wake_o,
  output logic [15:0] irq_vector_o,
  output logic [5:0] porta_dir_view_o,
  output logic [5:0] porta_data_view_o
);

  // Software-visible state and hidden prescale and cycle counters
  logic [7:0] ctrl_reg;
  logic gate_source_select_reg;
  logic overflow_flag_reg;
  logic overflow_irq_enable_reg;
  logic periph_irq_enable_reg;
  logic global_irq_enable_reg;
  tgc_count_t count_reg;
  tgc_count_t count_next;
  logic [2:0] prescale_reg;
  logic [1:0] qdiv_reg;
  // Edge detection state
  logic raw_reg;
  logic async_prev_reg;
  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;
  logic armed_reg;
  // Bus state
  logic pready_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  // Output flops
  logic irq_reg;
  logic wake_reg;
  logic lp_osc_run_reg;
  logic [5:0] dir_view_reg;
  logic [5:0] data_view_reg;

  // Divide ratio mask: 00,01,10,11 give 1,2,4,8
  function automatic logic [2:0] prescale_mask(input logic [1:0] sel);
    unique case (sel)
      2'b00: prescale_mask = 3'h0;
      2'b01: prescale_mask = 3'h1;
      2'b10: prescale_mask = 3'h3;
      2'b11: prescale_mask = 3'h7;
    endcase
  endfunction

  // Control fields
  logic timer_on, count_source_select, sync_bypass, lp_osc_enable, gate_enable, gate_invert;
  logic [1:0] prescale_select;
  assign timer_on = ctrl_reg[`TGC_B_ON];
  assign count_source_select = ctrl_reg[`TGC_B_CS];
  assign sync_bypass = ctrl_reg[`TGC_B_SYNC];
  assign lp_osc_enable = ctrl_reg[`TGC_B_OSCEN];
  assign prescale_select = ctrl_reg[`TGC_B_PS_LO +: 2];
  assign gate_enable = ctrl_reg[`TGC_B_GE];
  assign gate_invert = ctrl_reg[`TGC_B_GINV];

  // Bus decode; a write lands only on the edge that completes the access
  logic bus_access;
  logic wr_en;
  logic wr_ctrl;
  logic wr_lo;
  logic wr_hi;
  logic wr_cmp;
  logic wr_flag;
  logic wr_ien;
  logic wr_ictl;
  logic addr_ok;
  assign bus_access = psel_i && penable_i;
  assign wr_en = bus_access && pready_reg && pwrite_i;
  assign wr_ctrl = wr_en && (paddr_i == `TGC_OFS_CTRL);
  assign wr_lo = wr_en && (paddr_i == `TGC_OFS_CNT_LO);
  assign wr_hi = wr_en && (paddr_i == `TGC_OFS_CNT_HI);
  assign wr_cmp = wr_en && (paddr_i == `TGC_OFS_CMP_CTRL);
  assign wr_flag = wr_en && (paddr_i == `TGC_OFS_FLAG);
  assign wr_ien = wr_en && (paddr_i == `TGC_OFS_IRQ_EN);
  assign wr_ictl = wr_en && (paddr_i == `TGC_OFS_IRQ_CTRL);
  assign addr_ok = (paddr_i[1:0] == 2'b00) && (paddr_i <= `TGC_OFS_PORTA);

  // Oscillator used only when the system clock leaves it free
  logic lp_osc_active;
  assign lp_osc_active = lp_osc_enable && osc_option_ok_i;

  // Gate: selected source, optional invert, only when enabled
  logic gate_sel;
  logic gate_open;
  assign gate_sel = gate_source_select_reg ? comparator2_output_i : gate_pin_i;
  assign gate_open = !gate_enable || (gate_invert ? gate_sel : !gate_sel);

  // Source mode
  tgc_src_t src_mode;
  assign src_mode = !count_source_select ? TGC_SRC_INTERNAL :
                    (sync_bypass ? TGC_SRC_EXT_ASYNC : TGC_SRC_EXT_SYNC);

  // External level, from oscillator or pin
  logic ext_level;
  assign ext_level = lp_osc_active ? lp_osc_clk_i : ext_count_input_i;

  // Bypass path samples once; synchronizer adds two stages and idles in sleep
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      raw_reg <= 1'b0;
      async_prev_reg <= 1'b0;
    end else begin
      raw_reg <= ext_level;
      async_prev_reg <= raw_reg;
    end
  end

  // Synchronizer holds its state in sleep
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else if (!sleep_i) begin
      sync1_reg <= ext_level;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Edges of the chosen path
  // Switching paths mid-run can drop or add one edge; accepted, not hidden
  logic ext_now, ext_prev, ext_rise, ext_fall;
  assign ext_now = sync_bypass ? raw_reg : sync2_reg;
  assign ext_prev = sync_bypass ? async_prev_reg : sync3_reg;
  assign ext_rise = ext_now && !ext_prev;
  assign ext_fall = !ext_now && ext_prev;

  // A falling edge must be seen before the first counted rising edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      armed_reg <= 1'b0;
    end else if (!count_source_select || !timer_on) begin
      armed_reg <= 1'b0;
    end else if (ext_fall) begin
      armed_reg <= 1'b1;
    end
  end

  // Instruction cycle tick, system clock over four
  logic int_tick;
  assign int_tick = (qdiv_reg == 2'(`TGC_CLKS_PER_CYCLE - 1));
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      qdiv_reg <= 2'h0;
    end else begin
      qdiv_reg <= qdiv_reg + 2'h1;
    end
  end

  // Raw count event before prescale; sleep stops all but the bypass path
  logic src_event;
  logic run_ok;
  always_comb begin
    unique case (src_mode)
      TGC_SRC_INTERNAL: src_event = int_tick && !sleep_i;
      TGC_SRC_EXT_SYNC: src_event = ext_rise && armed_reg && !sleep_i;
      TGC_SRC_EXT_ASYNC: src_event = ext_rise && armed_reg;
      default: src_event = 1'b0;
    endcase
  end
  assign run_ok = timer_on && gate_open;

  // Prescaler; low bits cycle so the mask picks one event in 2^n
  logic count_wr;
  logic inc;
  assign count_wr = wr_lo || wr_hi;
  assign inc = run_ok && src_event &&
               ((prescale_reg & prescale_mask(prescale_select)) ==
                prescale_mask(prescale_select));
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prescale_reg <= 3'h0;
    end else if (count_wr) begin
      prescale_reg <= 3'h0;
    end else if (run_ok && src_event) begin
      prescale_reg <= prescale_reg + 3'h1;
    end
  end

  // Count pair; a byte write sets its byte, the other byte still takes a coincident increment
  always_comb begin
    count_next = count_reg;
    if (inc) begin
      count_next = count_reg + 16'h0001;
    end
    if (wr_lo) begin
      count_next[7:0] = pwdata_i[7:0];
    end
    if (wr_hi) begin
      count_next[15:8] = pwdata_i[7:0];
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_reg <= 16'h0000;
    end else begin
      count_reg <= count_next;
    end
  end

  // Overflow flag: rollover sets, software write of 0 clears; set wins
  logic rollover;
  assign rollover = inc && (count_reg == `TGC_CNT_MAX);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overflow_flag_reg <= 1'b0;
    end else if (rollover) begin
      overflow_flag_reg <= 1'b1;
    end else if (wr_flag) begin
      overflow_flag_reg <= pwdata_i[`TGC_B_OVF];
    end
  end

  // Control and enable registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `TGC_RST_CTRL;
      gate_source_select_reg <= 1'(`TGC_RST_CMP >> `TGC_B_GSS);
      overflow_irq_enable_reg <= 1'b0;
      periph_irq_enable_reg <= 1'b0;
      global_irq_enable_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= pwdata_i[7:0];
      end
      if (wr_cmp) begin
        gate_source_select_reg <= pwdata_i[`TGC_B_GSS];
      end
      if (wr_ien) begin
        overflow_irq_enable_reg <= pwdata_i[`TGC_B_OVF];
      end
      if (wr_ictl) begin
        periph_irq_enable_reg <= pwdata_i[`TGC_B_PERIPH_IRQ_ENABLE];
        global_irq_enable_reg <= pwdata_i[`TGC_B_GIE];
      end
    end
  end

  // Interrupt, wake and port views, all registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_reg <= 1'b0;
      wake_reg <= 1'b0;
      lp_osc_run_reg <= 1'b0;
      dir_view_reg <= 6'h00;
      data_view_reg <= 6'h00;
    end else begin
      irq_reg <= overflow_flag_reg && overflow_irq_enable_reg &&
                 periph_irq_enable_reg && global_irq_enable_reg;
      wake_reg <= overflow_flag_reg && overflow_irq_enable_reg &&
                  periph_irq_enable_reg && timer_on;
      lp_osc_run_reg <= lp_osc_active;
      dir_view_reg <= porta_dir_i | (lp_osc_active ? 6'h30 : 6'h00);
      data_view_reg <= porta_data_i & (lp_osc_active ? 6'h0F : 6'h3F);
    end
  end

  // Read mux; bits above the register width read zero
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (paddr_i)
      `TGC_OFS_CTRL: rd_word[7:0] = ctrl_reg;
      `TGC_OFS_CNT_LO: rd_word[7:0] = count_reg[7:0];
      `TGC_OFS_CNT_HI: rd_word[7:0] = count_reg[15:8];
      `TGC_OFS_CMP_CTRL: rd_word[`TGC_B_GSS] = gate_source_select_reg;
      `TGC_OFS_FLAG: rd_word[`TGC_B_OVF] = overflow_flag_reg;
      `TGC_OFS_IRQ_EN: rd_word[`TGC_B_OVF] = overflow_irq_enable_reg;
      `TGC_OFS_IRQ_CTRL: rd_word[7:6] = {global_irq_enable_reg, periph_irq_enable_reg};
      `TGC_OFS_PORTA: rd_word[13:0] = {2'b00, dir_view_reg, data_view_reg};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // One wait state: ready rises in the second access cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= bus_access && !pready_reg;
      if (bus_access && !pready_reg) begin
        prdata_reg <= pwrite_i ? 32'h0000_0000 : rd_word;
        pslverr_reg <= !addr_ok;
      end else begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign irq_o = irq_reg;
  assign wake_o = wake_reg;
  assign irq_vector_o = `TGC_ISR_VECTOR;
  assign lp_osc_run_o = lp_osc_run_reg;
  assign porta_dir_view_o = dir_view_reg;
  assign porta_data_view_o = data_view_reg;

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_at_max;
    inc && (count_reg == `TGC_CNT_MAX) && !count_wr;
  endsequence
  sequence s_wrapped;
    (count_reg == 16'h0000) && overflow_flag_reg;
  endsequence

  property p_rollover;
    s_at_max |=> s_wrapped;
  endproperty
  a_rollover: assert property (p_rollover) else $error("rollover missed");

  property p_write_low;
    wr_lo && !wr_hi |=> count_reg[7:0] == $past(pwdata_i[7:0]);
  endproperty
  a_write_low: assert property (p_write_low) else $error("low write lost");

  property p_prescale_clear;
    count_wr |=> prescale_reg == 3'h0;
  endproperty
  a_prescale_clear: assert property (p_prescale_clear) else $error("prescale kept");

  property p_off_hold;
    !timer_on && !count_wr |=> count_reg == $past(count_reg);
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("count while off");

  property p_gate_hold;
    gate_enable && (gate_invert ? !gate_sel : gate_sel) && !count_wr |=> $stable(count_reg);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("count while gated");

  property p_sleep_hold;
    sleep_i && (src_mode != TGC_SRC_EXT_ASYNC) && !count_wr |=> $stable(count_reg);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("count in sleep");

  property p_div1_tick;
    (src_mode == TGC_SRC_INTERNAL) && timer_on && gate_open && !sleep_i &&
      (prescale_select == 2'b00) && int_tick && !count_wr
      |=> count_reg == $past(count_reg) + 16'h0001;
  endproperty
  a_div1_tick: assert property (p_div1_tick) else $error("tick not counted");

  property p_unarmed;
    count_source_select && !armed_reg && !count_wr |=> $stable(count_reg);
  endproperty
  a_unarmed: assert property (p_unarmed) else $error("count before fall");

  property p_irq;
    irq_o == $past(overflow_flag_reg && overflow_irq_enable_reg &&
                   periph_irq_enable_reg && global_irq_enable_reg);
  endproperty
  a_irq: assert property (p_irq) else $error("irq gating wrong");

  property p_osc_view;
    lp_osc_active |=> porta_dir_view_o[5:4] == 2'b11 && porta_data_view_o[5:4] == 2'b00;
  endproperty
  a_osc_view: assert property (p_osc_view) else $error("port view wrong");

endmodule
`default_nettype wire

// File: dv/tgc_ext_src.sv
`timescale 1ns/100ps
`default_nettype none
module tgc_ext_src (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Frame control from the bench
  input wire logic run_i,
  input wire logic idle_i,
  input wire logic [3:0] half_i,
  // Pin side
  output logic ext_o,
  output logic osc_o,
  output logic [7:0] rises_o
);
  logic [3:0] tick_reg;
  logic run_q;
  // Square wave only inside a frame; the pin rests at its idle level between frames
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      tick_reg <= 4'h0;
      ext_o <= idle_i;
    end else if (tick_reg == half_i - 4'h1) begin
      tick_reg <= 4'h0;
      ext_o <= ~ext_o;
    end else begin
      tick_reg <= tick_reg + 4'h1;
    end
  end
  // Rising edges sent in the current frame, so the bench knows what to expect
  always_ff @(posedge clk_i) begin
    run_q <= run_i;
    if (rst_i || (run_i && !run_q)) begin
      rises_o <= 8'h00;
    end else if (run_i && tick_reg == half_i - 4'h1 && !ext_o) begin
      rises_o <= rises_o + 8'h01;
    end
  end
  // The crystal shares the count path, so it carries the same wave
  assign osc_o = ext_o;
endmodule
`default_nettype wire

// File: dv/tgc_timer_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "tgc_consts.svh"
module tgc_timer_tb;
  import tgc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic gate_pin = 1'b1;
  logic cmp2 = 1'b0;
  logic sleep = 1'b0;
  logic osc_ok = 1'b0;
  logic run = 1'b0;
  logic idle = 1'b1;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ext;
  logic osc;
  logic osc_run;
  logic irq;
  logic wake;
  logic [15:0] vec;
  logic [5:0] dir_view;
  logic [5:0] data_view;
  logic [7:0] rises;
  logic [31:0] rd_data;
  logic rd_err;
  int n_fail = 0;
  int samples_checked = 0;
  // Clock
  always #5 clk_i = ~clk_i;
  tgc_timer tgc_timer_i (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .ext_count_input_i(ext), .lp_osc_clk_i(osc),
    .gate_pin_i(gate_pin), .comparator2_output_i(cmp2), .sleep_i(sleep),
    .osc_option_ok_i(osc_ok), .porta_dir_i(6'h03), .porta_data_i(6'h3F),
    .lp_osc_run_o(osc_run), .irq_o(irq), .wake_o(wake), .irq_vector_o(vec),
    .porta_dir_view_o(dir_view), .porta_data_view_o(data_view));
  tgc_ext_src tgc_ext_src_i (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .idle_i(idle),
    .half_i(4'h4), .ext_o(ext), .osc_o(osc), .rises_o(rises));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_rng(input string what, input logic [31:0] lo, input logic [31:0] hi,
                         input logic [31:0] got);
    samples_checked++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      n_fail++;
      $display("unexpected %s: expected %0d..%0d seen %h", what, lo, hi, got);
    end
  endtask
  // One APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    // No assumed latency; only the watchdog ends a hung access
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, exp, rd_data);
  endtask
  // Counts are only written while the timer is stopped
  task automatic clr_cnt();
    wr(`TGC_OFS_CNT_LO, 32'h0000_0000);
    wr(`TGC_OFS_CNT_HI, 32'h0000_0000);
  endtask
  // Watchdog: the whole sequence needs a few thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    stop_test();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("ctrl reset", `TGC_OFS_CTRL, 32'h0000_0000);
    rd_chk("cmp ctrl reset", `TGC_OFS_CMP_CTRL, 32'h0000_0002);
    chk("mapped error", 32'h0000_0000, {31'h0000_0000, rd_err});
    rd_chk("unmapped data", 12'h020, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, {31'h0000_0000, rd_err});
    chk("vector", 32'h0000_0004, {16'h0000, vec});
    $display("test reset done");
    for (int ps = 0; ps < 4; ps++) begin
      clr_cnt();
      wr(`TGC_OFS_CTRL, 32'h0000_0001 | (ps << 4));
      repeat (256) @(posedge clk_i);
      wr(`TGC_OFS_CTRL, 32'h0000_0000);
      apb(1'b0, `TGC_OFS_CNT_LO, 32'h0000_0000);
      chk_rng("prescaled count", 256 >> (ps + 2), (264 >> (ps + 2)) + 1, rd_data);
      rd_chk("stopped count", `TGC_OFS_CNT_LO, rd_data);
    end
    $display("test prescale done");
    clr_cnt();
    wr(`TGC_OFS_CTRL, 32'h0000_00C1);
    repeat (64) @(posedge clk_i);
    rd_chk("gate closed", `TGC_OFS_CNT_LO, 32'h0000_0000);
    cmp2 <= 1'b1;
    repeat (64) @(posedge clk_i);
    wr(`TGC_OFS_CTRL, 32'h0000_0000);
    apb(1'b0, `TGC_OFS_CNT_LO, 32'h0000_0000);
    chk_rng("gate open cmp", 15, 19, rd_data);
    clr_cnt();
    wr(`TGC_OFS_CMP_CTRL, 32'h0000_0000);
    gate_pin <= 1'b0;
    wr(`TGC_OFS_CTRL, 32'h0000_0041);
    repeat (64) @(posedge clk_i);
    wr(`TGC_OFS_CTRL, 32'h0000_0000);
    apb(1'b0, `TGC_OFS_CNT_LO, 32'h0000_0000);
    chk_rng("gate open pin", 16, 19, rd_data);
    $display("test gate done");
    // Sync, async in sleep, then a line resting low whose first rise is ignored
    for (int m = 0; m < 3; m++) begin
      idle <= (m != 2);
      clr_cnt();
      sleep <= (m == 1);
      wr(`TGC_OFS_CTRL, (m == 1) ? 32'h0000_0007 : 32'h0000_0003);
      run <= 1'b1;
      repeat (200) @(posedge clk_i);
      run <= 1'b0;
      repeat (8) @(posedge clk_i);
      wr(`TGC_OFS_CTRL, 32'h0000_0000);
      sleep <= 1'b0;
      apb(1'b0, `TGC_OFS_CNT_LO, 32'h0000_0000);
      chk_rng("ext count", rises - ((m == 2) ? 2 : 1), rises - ((m == 2) ? 1 : 0),
              rd_data);
    end
    clr_cnt();
    sleep <= 1'b1;
    wr(`TGC_OFS_CTRL, 32'h0000_0001);
    repeat (64) @(posedge clk_i);
    wr(`TGC_OFS_CTRL, 32'h0000_0000);
    sleep <= 1'b0;
    rd_chk("sleep internal", `TGC_OFS_CNT_LO, 32'h0000_0000);
    $display("test external done");
    osc_ok <= 1'b1;
    wr(`TGC_OFS_CTRL, 32'h0000_0008);
    repeat (3) @(posedge clk_i);
    chk("osc run", 32'h0000_0001, {31'h0000_0000, osc_run});
    chk("dir view", 32'h0000_0033, {26'h000_0000, dir_view});
    chk("data view", 32'h0000_000F, {26'h000_0000, data_view});
    rd_chk("port view", `TGC_OFS_PORTA, 32'h0000_0CCF);
    osc_ok <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("osc refused", 32'h0000_0000, {31'h0000_0000, osc_run});
    chk("dir view off", 32'h0000_0003, {26'h000_0000, dir_view});
    chk("data view off", 32'h0000_003F, {26'h000_0000, data_view});
    wr(`TGC_OFS_CTRL, 32'h0000_0000);
    $display("test oscillator done");
    wr(`TGC_OFS_FLAG, 32'h0000_0000);
    wr(`TGC_OFS_CNT_LO, 32'h0000_00FF);
    wr(`TGC_OFS_CNT_HI, 32'h0000_00FF);
    wr(`TGC_OFS_IRQ_EN, 32'h0000_0001);
    wr(`TGC_OFS_IRQ_CTRL, 32'h0000_0040);
    wr(`TGC_OFS_CTRL, 32'h0000_0001);
    repeat (16) @(posedge clk_i);
    chk("wake", 32'h0000_0001, {31'h0000_0000, wake});
    chk("irq no global", 32'h0000_0000, {31'h0000_0000, irq});
    wr(`TGC_OFS_IRQ_CTRL, 32'h0000_00C0);
    repeat (2) @(posedge clk_i);
    chk("irq", 32'h0000_0001, {31'h0000_0000, irq});
    wr(`TGC_OFS_CTRL, 32'h0000_0000);
    rd_chk("flag", `TGC_OFS_FLAG, 32'h0000_0001);
    rd_chk("wrapped high", `TGC_OFS_CNT_HI, 32'h0000_0000);
    wr(`TGC_OFS_FLAG, 32'h0000_0000);
    repeat (2) @(posedge clk_i);
    chk("irq cleared", 32'h0000_0000, {31'h0000_0000, irq});
    chk("wake cleared", 32'h0000_0000, {31'h0000_0000, wake});
    $display("test overflow done");
    // Mid-run reset: the count left over from the overflow test must be gone
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("count after reset", `TGC_OFS_CNT_LO, 32'h0000_0000);
    rd_chk("gate source after reset", `TGC_OFS_CMP_CTRL, 32'h0000_0002);
    $display("test mid reset done");
    stop_test();
  end
endmodule
`default_nettype wire
